// file: rtl/sysref_cfg_pkg.sv
package sysref_cfg_pkg;

  // ****************************************
  // Sizes and serial frame
  // ****************************************
  localparam int unsigned NUM_GEN = 5;      // Four converter outputs plus logic output
  localparam int unsigned NUM_REGS = 8;     // Registers in this bank
  localparam int unsigned FRAME_BITS = 24;  // Read flag, address, data
  localparam logic [4:0] ADDR_LAST_BIT = 5'h07; // Count at which the address is complete
  localparam logic [4:0] FRAME_LAST_BIT = 5'h17; // Count at which the data is complete

  // ****************************************
  // Offsets
  // ****************************************
  localparam logic [6:0] ADDR_CAL_TRIGGER = 7'h00;
  localparam logic [6:0] ADDR_DELAY_GEN_CFG_B = 7'h12;
  localparam logic [6:0] ADDR_DELAY_GEN_CFG_C = 7'h13;
  localparam logic [6:0] ADDR_DELAY_GEN_CFG_D = 7'h14;
  localparam logic [6:0] ADDR_DELAY_GEN_CFG_E = 7'h15;
  localparam logic [6:0] ADDR_DELAY_SCALE_AND_DIV = 7'h16;
  localparam logic [6:0] ADDR_TEMP_PIN_AND_SCALE_CTRL = 7'h17;
  localparam logic [6:0] ADDR_TEMPERATURE_READBACK = 7'h18;
  localparam logic [6:0] ADDR_CLOCK_PATH_MODE = 7'h19;

  // ****************************************
  // Reset values, in bank order
  // ****************************************
  localparam logic [15:0] RST_DELAY_GEN_CFG = 16'hFE00;
  localparam logic [15:0] RST_DELAY_SCALE_AND_DIV = 16'h0800;
  localparam logic [15:0] RST_TEMP_PIN_AND_SCALE_CTRL = 16'h4000;
  localparam logic [15:0] RST_TEMPERATURE_READBACK = 16'h0FFE;
  localparam logic [15:0] RST_CLOCK_PATH_MODE = 16'h0211;
  localparam logic [10:0] THERM_CODE_IDLE = 11'h7FF;
  localparam logic [15:0] TEMP_RW_MASK = 16'h3001; // Only bits 13:12 and 0 are writable

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned STEP_I_LSB = 9;
  localparam int unsigned PHASE_LSB = 7;
  localparam int unsigned STEP_Q_LSB = 0;
  localparam int unsigned RANGE_B_LSB = 14;
  localparam int unsigned RANGE_A_LSB = 12;
  localparam int unsigned INTERP_DIV_LSB = 9;
  localparam int unsigned THERM_SENSOR_EN_BIT = 15;
  localparam int unsigned PIN_DRIVE_BIT = 13;
  localparam int unsigned PIN_FUNCTION_BIT = 6;
  localparam int unsigned RANGE_E_LSB = 4;
  localparam int unsigned RANGE_D_LSB = 2;
  localparam int unsigned RANGE_C_LSB = 0;
  localparam int unsigned THERM_CODE_LSB = 1;
  localparam int unsigned THERM_COUNTER_EN_BIT = 0;
  localparam int unsigned DIV_RESET_BIT = 6;
  localparam int unsigned RATIO_LSB = 3;
  localparam int unsigned FUNC_SEL_LSB = 0;
  localparam int unsigned CAL_POWERDOWN_BIT = 0;
  localparam int unsigned CAL_SOFT_RESET_BIT = 1;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [6:0] STEP_SUM = 7'h7F;
  localparam logic [1:0] RANGE_RESERVED = 2'h3;
  localparam logic [2:0] RATIO_MULT_MAX = 3'h4;

  typedef enum logic [2:0] {
    MODE_BUFFER = 3'h1,
    MODE_DIVIDER = 3'h2,
    MODE_MULTIPLIER = 3'h3
  } clock_mode_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ADDR = 2'h1,
    ST_DATA = 2'h2,
    ST_DONE = 2'h3
  } spi_state_type;

  // Decoded settings of one delay generator
  typedef struct packed {
    logic [6:0] step_inphase;
    logic [6:0] step_quad;
    logic quad_clock;
    logic [1:0] freq_range;
    logic range_valid;
    logic step_sum_ok;
  } delay_gen_type;

  // Effective main clock path
  typedef struct packed {
    clock_mode_type mode;
    logic [3:0] ratio;
    logic div_reset;
  } clock_path_type;

endpackage

// file: rtl/sysref_delay_and_mode_config.sv
`timescale 1ns/1ps
module sysref_delay_and_mode_config
  import sysref_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sck_i,
  input wire logic spi_sdi_i,
  input wire logic frame_request_input_i,
  input wire logic request_pin_function_i,
  input wire logic sync_enable_i,
  input wire logic lock_detect_i,
  input wire logic [10:0] thermal_code_i,
  input wire logic [6:0] frame_out_a_step_inphase_i,
  input wire logic [1:0] frame_out_a_interp_phase_i,
  output logic shared_output_pin_o,
  output logic shared_output_pin_oe_n_o,
  output sysref_cfg_pkg::delay_gen_type [4:0] delay_gen_o,
  output logic [4:0] interp_clock_divider_o,
  output logic thermal_sensor_enable_o,
  output logic thermal_counter_enable_o,
  output sysref_cfg_pkg::clock_path_type clock_path_o,
  output logic calibration_start_o
);
  import sysref_cfg_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pin_s1_q; // First stage, read only by the second
  logic [4:0] pin_s2_q; // Stable pin levels
  logic [10:0] therm_s1_q;
  logic [10:0] therm_s2_q;
  logic [10:0] therm_s3_q; // Third copy lets a settled code be told apart
  logic sck_prev_q; // For edge detection
  logic req_prev_q;

  // Two flops on the serial, request and lock pins and the sensor code before any logic looks at them
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_s1_q <= 5'h01;
      pin_s2_q <= 5'h01;
      therm_s1_q <= 11'h000;
      therm_s2_q <= 11'h000;
      therm_s3_q <= 11'h000;
      sck_prev_q <= 1'b0;
      req_prev_q <= 1'b0;
    end else begin
      pin_s1_q <= {lock_detect_i, frame_request_input_i, spi_sdi_i, spi_sck_i, spi_cs_n_i};
      pin_s2_q <= pin_s1_q;
      therm_s1_q <= thermal_code_i;
      therm_s2_q <= therm_s1_q;
      therm_s3_q <= therm_s2_q;
      sck_prev_q <= pin_s2_q[1];
      req_prev_q <= pin_s2_q[3];
    end
  end

  logic cs_n;
  logic sck_rise;
  logic sck_fall;
  logic sdi;
  logic req_rise;
  assign cs_n = pin_s2_q[0];
  assign sck_rise = pin_s2_q[1] && !sck_prev_q;
  assign sck_fall = !pin_s2_q[1] && sck_prev_q;
  assign sdi = pin_s2_q[2];
  assign req_rise = pin_s2_q[3] && !req_prev_q;

  // ****************************************
  // Serial slave and register bank
  // ****************************************
  spi_state_type state_q, state_d;
  logic [4:0] bit_cnt_q, bit_cnt_d; // Bits taken in this frame
  logic [23:0] shift_in_q, shift_in_d; // Incoming frame
  logic [15:0] shift_out_q, shift_out_d; // Readback data, MSB first
  logic read_q, read_d; // Frame is a read
  logic [6:0] addr_q, addr_d;
  logic [15:0] bank_q [NUM_REGS];
  logic [15:0] bank_d [NUM_REGS];
  logic [10:0] thermal_code_q, thermal_code_d;
  logic cal_go; // Qualified write to the trigger address
  logic write_commit; // Last data bit of a write frame
  logic in_bank;
  logic [2:0] idx; // Bank index of the current address
  logic [15:0] read_word;

  // Bank reset image
  function automatic logic [15:0] reset_word(input int unsigned i);
    case (i)
      4: reset_word = RST_DELAY_SCALE_AND_DIV;
      5: reset_word = RST_TEMP_PIN_AND_SCALE_CTRL;
      6: reset_word = RST_TEMPERATURE_READBACK;
      7: reset_word = RST_CLOCK_PATH_MODE;
      default: reset_word = RST_DELAY_GEN_CFG;
    endcase
  endfunction

  assign in_bank = (addr_q >= ADDR_DELAY_GEN_CFG_B) && (addr_q <= ADDR_CLOCK_PATH_MODE);
  assign idx = 3'(addr_q - ADDR_DELAY_GEN_CFG_B);

  // Readback word; the sensor field is live, never stored
  always_comb begin
    read_word = 16'h0000;
    if (in_bank) begin
      if (addr_q == ADDR_TEMPERATURE_READBACK) begin
        read_word = (bank_q[idx] & TEMP_RW_MASK) | {4'h0, thermal_code_q, 1'b0};
      end else begin
        read_word = bank_q[idx];
      end
    end
  end

  // Address is known one clock after its last bit, so load the readback then
  logic load_read;
  logic load_done_q; // Keeps a long sck high phase from reloading the word
  assign load_read = (state_q == ST_DATA) && (bit_cnt_q == 5'h08) && read_q && !sck_fall && !sck_rise;

  // Frame sequencing and register writes
  always_comb begin
    state_d = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_in_d = shift_in_q;
    shift_out_d = shift_out_q;
    read_d = read_q;
    addr_d = addr_q;
    bank_d = bank_q;
    cal_go = 1'b0;
    write_commit = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (!cs_n) begin
          state_d = ST_ADDR;
          bit_cnt_d = 5'h00;
        end
      end
      ST_ADDR, ST_DATA: begin
        if (cs_n) begin
          // Early release drops the frame without side effects
          state_d = ST_IDLE;
        end else if (sck_rise) begin
          shift_in_d = {shift_in_q[22:0], sdi};
          bit_cnt_d = bit_cnt_q + 5'h01;
          if (bit_cnt_q == ADDR_LAST_BIT) begin
            read_d = shift_in_d[7];
            addr_d = shift_in_d[6:0];
            state_d = ST_DATA;
          end else if (bit_cnt_q == FRAME_LAST_BIT) begin
            state_d = ST_DONE;
            write_commit = !read_q;
          end
        end else if (sck_fall && read_q && state_q == ST_DATA && bit_cnt_q > 5'h08) begin
          // Skip the fall right after the address so bit 15 is seen
          shift_out_d = {shift_out_q[14:0], 1'b0};
        end
      end
      ST_DONE: begin
        if (cs_n) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // A frame that has not started carries no read flag
    if (state_q == ST_IDLE) begin
      read_d = 1'b0;
    end
    // First load wins over any shift in the same cycle
    if (load_read && !load_done_q) begin
      shift_out_d = read_word;
    end
    if (write_commit && in_bank) begin
      // Reserved RW bits keep what the host writes
      if (addr_q == ADDR_TEMPERATURE_READBACK) begin
        bank_d[idx] = shift_in_d[15:0] & TEMP_RW_MASK;
      end else begin
        bank_d[idx] = shift_in_d[15:0];
      end
    end
    if (write_commit && addr_q == ADDR_CAL_TRIGGER) begin
      if (shift_in_d[CAL_SOFT_RESET_BIT]) begin
        for (int i = 0; i < NUM_REGS; i++) begin
          bank_d[i] = reset_word(i);
        end
      end else if (!shift_in_d[CAL_POWERDOWN_BIT]) begin
        cal_go = 1'b1;
      end
    end
  end

  // Sensor code is held at its idle value until both enables are on
  always_comb begin
    thermal_code_d = thermal_code_q;
    if (!(bank_q[5][THERM_SENSOR_EN_BIT] && bank_q[6][THERM_COUNTER_EN_BIT])) begin
      thermal_code_d = THERM_CODE_IDLE;
    end else if (therm_s2_q == therm_s3_q) begin
      // Only a code seen twice is taken, so a half-moved word never lands
      thermal_code_d = therm_s2_q;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 5'h00;
      shift_in_q <= 24'h000000;
      shift_out_q <= 16'h0000;
      read_q <= 1'b0;
      addr_q <= 7'h00;
      load_done_q <= 1'b0;
      thermal_code_q <= THERM_CODE_IDLE;
      for (int i = 0; i < NUM_REGS; i++) begin
        bank_q[i] <= reset_word(i);
      end
    end else begin
      state_q <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_in_q <= shift_in_d;
      shift_out_q <= shift_out_d;
      read_q <= read_d;
      addr_q <= addr_d;
      load_done_q <= load_read;
      thermal_code_q <= thermal_code_d;
      bank_q <= bank_d;
    end
  end

  // ****************************************
  // Decoded outputs
  // ****************************************
  delay_gen_type [4:0] gen_d;
  logic [6:0] gen_inphase [NUM_GEN];
  logic [1:0] gen_phase [NUM_GEN];
  logic [6:0] gen_quad [NUM_GEN];
  logic [1:0] gen_range [NUM_GEN];

  // Generator a takes its inphase step and phase from input ports, the others from the register below their own
  always_comb begin
    gen_inphase[0] = frame_out_a_step_inphase_i;
    gen_phase[0] = frame_out_a_interp_phase_i;
    for (int g = 1; g < NUM_GEN; g++) begin
      gen_inphase[g] = bank_q[g - 1][STEP_I_LSB +: 7];
      gen_phase[g] = bank_q[g - 1][PHASE_LSB +: 2];
    end
    for (int g = 0; g < NUM_GEN; g++) begin
      gen_quad[g] = bank_q[g][STEP_Q_LSB +: 7];
    end
    gen_range[0] = bank_q[4][RANGE_A_LSB +: 2];
    gen_range[1] = bank_q[4][RANGE_B_LSB +: 2];
    gen_range[2] = bank_q[5][RANGE_C_LSB +: 2];
    gen_range[3] = bank_q[5][RANGE_D_LSB +: 2];
    gen_range[4] = bank_q[5][RANGE_E_LSB +: 2];
  end

  for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
    always_comb begin
      gen_d[g].step_inphase = gen_inphase[g];
      gen_d[g].step_quad = gen_quad[g];
      gen_d[g].quad_clock = gen_phase[g][0] ^ gen_phase[g][1];
      gen_d[g].freq_range = gen_range[g];
      gen_d[g].range_valid = gen_range[g] != RANGE_RESERVED;
      // Only flags a host slip; the hardware does not correct it
      gen_d[g].step_sum_ok = 7'(gen_inphase[g] + gen_quad[g]) == STEP_SUM;
    end
    property p_quad_clock;
      @(posedge clk_i) disable iff (!resetn_i)
      (gen_phase[g] == 2'h1 || gen_phase[g] == 2'h2) |=> delay_gen_o[g].quad_clock;
    endproperty
    a_quad_clock: assert property (p_quad_clock) else $error("quadrature phase not selected");
    property p_range_flag;
      @(posedge clk_i) disable iff (!resetn_i)
      (gen_range[g] == RANGE_RESERVED) |=> !delay_gen_o[g].range_valid;
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("reserved range marked valid");
  end

  logic [4:0] interp_div_d;
  clock_path_type path_d;
  logic [2:0] ratio_field;
  logic [2:0] func_sel;
  logic sync_event;
  logic pin_out_d;

  assign ratio_field = bank_q[7][RATIO_LSB +: 3];
  assign func_sel = bank_q[7][FUNC_SEL_LSB +: 3];
  assign sync_event = req_rise && !request_pin_function_i && sync_enable_i;

  // Mode, ratio, divider reset and pin data
  always_comb begin
    case (bank_q[4][INTERP_DIV_LSB +: 3])
      3'h0: interp_div_d = 5'h02;
      3'h1: interp_div_d = 5'h04;
      3'h2: interp_div_d = 5'h08;
      3'h4: interp_div_d = 5'h10;
      default: interp_div_d = 5'h00; // Reserved code stops the divider
    endcase
    path_d.mode = MODE_BUFFER; // Reserved selector codes also buffer
    path_d.ratio = 4'h1;
    case (func_sel)
      MODE_DIVIDER: begin
        if (ratio_field != 3'h0) begin
          path_d.mode = MODE_DIVIDER;
          path_d.ratio = {1'b0, ratio_field} + 4'h1;
        end
      end
      MODE_MULTIPLIER: begin
        if (ratio_field != 3'h0 && ratio_field <= RATIO_MULT_MAX) begin
          path_d.mode = MODE_MULTIPLIER;
          path_d.ratio = {1'b0, ratio_field};
        end
      end
      default: begin
        path_d.mode = MODE_BUFFER;
      end
    endcase
    // Held for as long as the bit stays high
    path_d.div_reset = (path_d.mode == MODE_DIVIDER) && (bank_q[7][DIV_RESET_BIT] || sync_event);
    pin_out_d = bank_q[5][PIN_FUNCTION_BIT] ? (read_q && shift_out_q[15]) : pin_s2_q[4];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      delay_gen_o <= '0;
      interp_clock_divider_o <= 5'h10;
      clock_path_o <= '{mode: MODE_BUFFER, ratio: 4'h1, div_reset: 1'b0};
      calibration_start_o <= 1'b0;
      shared_output_pin_o <= 1'b0;
      shared_output_pin_oe_n_o <= 1'b1;
      thermal_sensor_enable_o <= 1'b0;
      thermal_counter_enable_o <= 1'b0;
    end else begin
      delay_gen_o <= gen_d;
      interp_clock_divider_o <= interp_div_d;
      clock_path_o <= path_d;
      calibration_start_o <= cal_go;
      shared_output_pin_o <= pin_out_d;
      shared_output_pin_oe_n_o <= !bank_q[5][PIN_DRIVE_BIT];
      thermal_sensor_enable_o <= bank_q[5][THERM_SENSOR_EN_BIT];
      thermal_counter_enable_o <= bank_q[6][THERM_COUNTER_EN_BIT];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_zero_write;
    write_commit && addr_q == ADDR_CAL_TRIGGER && !shift_in_d[CAL_SOFT_RESET_BIT] && !shift_in_d[CAL_POWERDOWN_BIT];
  endsequence
  property p_cal_start;
    @(posedge clk_i) disable iff (!resetn_i) s_zero_write |=> calibration_start_o ##1 !calibration_start_o;
  endproperty
  a_cal_start: assert property (p_cal_start) else $error("calibration pulse missing");
  property p_div_reset_mode;
    @(posedge clk_i) disable iff (!resetn_i) clock_path_o.div_reset |-> clock_path_o.mode == MODE_DIVIDER;
  endproperty
  a_div_reset_mode: assert property (p_div_reset_mode) else $error("divider reset outside divider mode");
  property p_sync_reset;
    @(posedge clk_i) disable iff (!resetn_i)
    (sync_event && func_sel == MODE_DIVIDER && ratio_field != 3'h0) |=> clock_path_o.div_reset;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync did not reset divider");
  property p_buffer_ignores;
    @(posedge clk_i) disable iff (!resetn_i)
    func_sel == MODE_BUFFER |=> clock_path_o.mode == MODE_BUFFER && clock_path_o.ratio == 4'h1;
  endproperty
  a_buffer_ignores: assert property (p_buffer_ignores) else $error("buffer mode used ratio");
  property p_div_ratio;
    @(posedge clk_i) disable iff (!resetn_i)
    (func_sel == MODE_DIVIDER && ratio_field != 3'h0) |=> clock_path_o.ratio == $past(ratio_field) + 3'h1;
  endproperty
  a_div_ratio: assert property (p_div_ratio) else $error("divide ratio wrong");
  property p_mult_fallback;
    @(posedge clk_i) disable iff (!resetn_i)
    (func_sel == MODE_MULTIPLIER && ratio_field > RATIO_MULT_MAX) |=> clock_path_o.mode == MODE_BUFFER;
  endproperty
  a_mult_fallback: assert property (p_mult_fallback) else $error("invalid multiplier not buffered");
  property p_interp_div;
    @(posedge clk_i) disable iff (!resetn_i) bank_q[4][INTERP_DIV_LSB +: 3] == 3'h4 |=> interp_clock_divider_o == 5'h10;
  endproperty
  a_interp_div: assert property (p_interp_div) else $error("divide by 16 not set");
  property p_pin_drive;
    @(posedge clk_i) disable iff (!resetn_i) $fell(bank_q[5][PIN_DRIVE_BIT]) |=> shared_output_pin_oe_n_o;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not released");
  property p_thermal_idle;
    @(posedge clk_i) disable iff (!resetn_i) !thermal_sensor_enable_o [*2] |-> thermal_code_q == THERM_CODE_IDLE;
  endproperty
  a_thermal_idle: assert property (p_thermal_idle) else $error("sensor code shown while disabled");
endmodule

// file: verification/serial_host_model.sv
`timescale 1ns/1ps
// Serial host that frames 24-bit register accesses
module serial_host_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic pin_oe_n_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic sdi_o
);
  int unsigned hp = 5; // Clocks per sck half, at least 1; reads need 4
  logic [15:0] rd_q; // Bits captured in the last frame
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Data moves while sck is low; pin is taken just before each rise
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] d);
    logic [23:0] f;
    f = {rd, a, d};
    cs_n_o = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      sdi_o = f[b];
      repeat (hp) @(negedge clk_i);
      // A released pin carries nothing, so the bit is garbled
      if (b < 16) rd_q[b] = pin_oe_n_i ? ~rd_q[b] : pin_i;
      sck_o = 1'b1;
      repeat (hp) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (hp) @(negedge clk_i);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o; // Line floats between frames
    repeat (hp) @(negedge clk_i);
  endtask
endmodule

// file: verification/tb_sysref_delay_and_mode_config.sv
`timescale 1ns/1ps
module tb_sysref_delay_and_mode_config;
  import sysref_cfg_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cs_n, sck, sdi, req, req_fn, sync_en, lock, pin, oe_n, ts_en, tc_en, cal;
  logic [10:0] tcode;
  logic [6:0] a_step, i, q;
  logic [1:0] a_phase;
  logic [4:0] idiv;
  delay_gen_type [4:0] gens;
  clock_path_type cpath;
  logic [15:0] sh [8]; // Bank shadow, index is offset minus 0x12
  logic [15:0] v;
  int error_cnt = 0;
  int n_compared = 0;
  int dr_cnt = 0; // Divider reset cycles seen
  int cal_cnt = 0; // Calibration pulses seen
  int seed;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (cpath.div_reset === 1'b1) dr_cnt++;
    if (cal === 1'b1) cal_cnt++;
  end
  sysref_delay_and_mode_config i_sysref_delay_and_mode_config (
    .clk_i(clk_i), .resetn_i(resetn_i), .spi_cs_n_i(cs_n), .spi_sck_i(sck), .spi_sdi_i(sdi),
    .frame_request_input_i(req), .request_pin_function_i(req_fn), .sync_enable_i(sync_en),
    .lock_detect_i(lock), .thermal_code_i(tcode), .frame_out_a_step_inphase_i(a_step),
    .frame_out_a_interp_phase_i(a_phase), .shared_output_pin_o(pin), .shared_output_pin_oe_n_o(oe_n),
    .delay_gen_o(gens), .interp_clock_divider_o(idiv), .thermal_sensor_enable_o(ts_en),
    .thermal_counter_enable_o(tc_en), .clock_path_o(cpath), .calibration_start_o(cal));
  serial_host_model i_serial_host_model (.clk_i(clk_i), .pin_i(pin), .pin_oe_n_i(oe_n),
    .cs_n_o(cs_n), .sck_o(sck), .sdi_o(sdi));
  // ****
  // Expectations
  // ****
  function automatic delay_gen_type exp_gen(input int g);
    delay_gen_type e;
    logic [1:0] ph;
    e.step_inphase = (g == 0) ? a_step : sh[(g + 7) % 8][15:9];
    e.step_quad = sh[g][6:0];
    ph = (g == 0) ? a_phase : sh[(g + 7) % 8][8:7];
    e.quad_clock = ph[0] ^ ph[1];
    e.freq_range = (g < 2) ? sh[4][12 + 2 * g +: 2] : sh[5][2 * g - 4 +: 2];
    e.range_valid = e.freq_range != 2'h3;
    e.step_sum_ok = ({1'b0, e.step_inphase} + {1'b0, e.step_quad}) == 8'h7F;
    return e;
  endfunction
  function automatic logic [4:0] exp_div(input logic [2:0] c);
    return (c == 3'h4) ? 5'h10 : (c <= 3'h2) ? 5'h02 << c : 5'h00;
  endfunction
  function automatic clock_path_type exp_cp(input logic [15:0] w);
    clock_path_type e;
    e.mode = MODE_BUFFER;
    e.ratio = 4'h1;
    if (w[2:0] == 3'h2 && w[5:3] != 3'h0) begin
      e.mode = MODE_DIVIDER;
      e.ratio = {1'b0, w[5:3]} + 4'h1;
    end
    if (w[2:0] == 3'h3 && w[5:3] != 3'h0 && w[5:3] <= 3'h4) begin
      e.mode = MODE_MULTIPLIER;
      e.ratio = {1'b0, w[5:3]};
    end
    e.div_reset = w[6] && e.mode == MODE_DIVIDER;
    return e;
  endfunction
  // Temperature word reads the live code only with both enables on
  function automatic logic [15:0] exp_rd(input logic [6:0] a);
    if (a == ADDR_TEMPERATURE_READBACK) return {2'h0, sh[6][13:12], (sh[5][15] && sh[6][0]) ? tcode : 11'h7FF, sh[6][0]};
    if (a >= 7'h12 && a <= 7'h19) return sh[a - 7'h12];
    return 16'h0000;
  endfunction
  // ****
  // Shared tasks
  // ****
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic load_rst();
    for (int n = 0; n < 4; n++) sh[n] = 16'hFE00;
    sh[4] = 16'h0800;
    sh[5] = 16'h4000;
    sh[6] = 16'h0FFE;
    sh[7] = 16'h0211;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    i_serial_host_model.xfer(1'b0, a, d);
    if (a >= 7'h12 && a <= 7'h19) sh[a - 7'h12] = d;
  endtask
  task automatic chk_rd(input logic [6:0] a);
    i_serial_host_model.xfer(1'b1, a, 16'h0000);
    chk("readback", exp_rd(a), i_serial_host_model.rd_q);
  endtask
  task automatic chk_out();
    for (int g = 0; g < 5; g++) chk("delay_gen", exp_gen(g), gens[g]);
    chk("interp_div", exp_div(sh[4][11:9]), idiv);
    chk("clock_path", exp_cp(sh[7]), cpath);
    chk("drive_oe_n", !sh[5][13], oe_n);
    chk("sensor_en", {sh[5][15], sh[6][0]}, {ts_en, tc_en});
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk_i);
    error_cnt++;
    end_sim();
  end
  // ****
  // Main sequence
  // ****
  initial begin
    seed = 32'hD51C0C3C;
    {req, req_fn, sync_en, lock} = 4'h0;
    tcode = 11'h155;
    a_step = 7'h00;
    a_phase = 2'h0;
    load_rst();
    repeat (10) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
    chk_out();
    wr(ADDR_TEMP_PIN_AND_SCALE_CTRL, 16'h6040);
    wr(7'h1A, 16'hFFFF);
    for (int a = 8'h11; a <= 8'h1A; a++) chk_rd(a[6:0]);
    $display("test reset_and_map done");
    // Every divider code once, other fields random
    for (int k = 0; k < 8; k++) begin
      a_step = 7'($random(seed));
      a_phase = 2'($random(seed));
      tcode = 11'($random(seed));
      for (int r = 0; r < 5; r++) begin
        i = (r == 0) ? a_step : sh[(r + 7) % 8][15:9];
        q = ($random(seed) & 1) ? 7'h7F - i : 7'($random(seed));
        v = {9'($random(seed)), q};
        if (r == 4) v[11:7] = {k[2:0], 2'h0};
        wr(ADDR_DELAY_GEN_CFG_B + 7'(r), v);
      end
      wr(ADDR_TEMP_PIN_AND_SCALE_CTRL, {k[1], 2'h3, 6'h00, 1'b1, 6'($random(seed))});
      wr(ADDR_TEMPERATURE_READBACK, {4'h0, 11'($random(seed)), k[0]});
      chk_out();
      for (int a = 8'h12; a <= 8'h19; a++) chk_rd(a[6:0]);
    end
    $display("test delay_config done");
    // Every selector and ratio pair, quick and slow host alternating
    for (int m = 0; m < 64; m++) begin
      i_serial_host_model.hp = m[0] ? 4 : 7;
      v = {9'h004, 1'($random(seed)), m[5:0]};
      wr(ADDR_CLOCK_PATH_MODE, v);
      chk("clock_path", exp_cp(v), cpath);
    end
    i_serial_host_model.hp = 5;
    $display("test clock_mode done");
    wr(ADDR_CLOCK_PATH_MODE, 16'h0212);
    for (int t = 0; t < 3; t++) begin
      {req_fn, sync_en} = (t == 0) ? 2'b01 : (t == 1) ? 2'b11 : 2'b00;
      dr_cnt = 0;
      req = 1'b1;
      repeat (10) @(negedge clk_i);
      req = 1'b0;
      repeat (4) @(negedge clk_i);
      chk("sync_div_reset", t == 0, dr_cnt);
    end
    wr(ADDR_TEMP_PIN_AND_SCALE_CTRL, 16'h6000);
    for (int t = 1; t >= 0; t--) begin
      lock = t[0];
      repeat (5) @(negedge clk_i);
      chk("lock_on_pin", t[0], pin);
    end
    $display("test sync_and_pin done");
    // Plain write, powerdown, then software reset
    for (int t = 0; t < 3; t++) begin
      cal_cnt = 0;
      wr(ADDR_CAL_TRIGGER, 16'(t)); // divider mode is set, so no multiplier preparation is owed
      chk("calibration", t == 0, cal_cnt);
    end
    load_rst();
    chk_out();
    $display("test calibration done");
    end_sim();
  end
endmodule
